/* core/dds_ctrl_pkg.sv */
package dds_ctrl_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ACTIVE = 8'h04;
    localparam logic [7:0] OFF_SCALE = 8'h08;
    localparam logic [7:0] OFF_RAMP = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    // Control bit positions
    localparam int BIT_RAM_EN = 31;
    localparam int BIT_RAM_DEST = 30;
    localparam int LOOP_HI = 29;
    localparam int LOOP_LO = 27;
    localparam int BIT_RAMP_LOAD = 26;
    localparam int BIT_KEY_EN = 25;
    localparam int BIT_KEY_AUTO = 24;
    localparam int BIT_AUTO_SYNC = 23;
    // Values after reset
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] SCALE_RST = 16'h0000;
    localparam logic [7:0] RAMP_RST = 8'h00;
    localparam logic [13:0] FULL_SCALE = 14'h3fff;
    // Ramp timer count at which it times out
    localparam logic [7:0] TIMEOUT_COUNT = 8'h01;
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Data source selection for the phase accumulator and offset adder
    typedef enum logic [1:0] {SRC_TONE, SRC_RAM_FREQ, SRC_RAM_PHASE} ram_route_t;
endpackage : dds_ctrl_pkg

/* core/sync_two_flop.sv */
// Two-flop synchroniser for pin levels
module sync_two_flop #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    // First stage, read only by the second
    logic [WIDTH-1:0] meta_r;

    initial begin
        if (WIDTH < 1) begin
            $error("sync_two_flop needs WIDTH of at least 1");
        end
    end

    // Both stages clear on reset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta_r <= '0;
            syncOut <= '0;
        end else begin
            meta_r <= asyncIn;
            syncOut <= meta_r;
        end
    end
endmodule : sync_two_flop

/* core/amp_ramp_timer.sv */
// Amplitude ramp rate timer: counts down, ticks and reloads at one
module amp_ramp_timer
    import dds_ctrl_pkg::*;
#(
    parameter int RATE_W = 8
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [RATE_W-1:0] rateWord,
    input wire logic ioUpdate,
    input wire logic loadOnUpdate,
    output logic rampTick,
    output logic [RATE_W-1:0] timerCount
);
    // Reload request: timeout always, update only when allowed
    logic timeout;
    logic reload;
    logic [RATE_W-1:0] loadValue;

    initial begin
        if (RATE_W < 2 || RATE_W > 16) begin
            $error("amp_ramp_timer RATE_W must lie in 2..16");
        end
    end

    assign timeout = (timerCount == RATE_W'(TIMEOUT_COUNT));
    assign reload = timeout || (loadOnUpdate && ioUpdate);
    // A zero rate would wrap through the whole count range before timing out, so it is treated as one
    assign loadValue = (rateWord == '0) ? RATE_W'(TIMEOUT_COUNT) : rateWord;
    assign rampTick = timeout;

    // Down counter
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            timerCount <= RATE_W'(TIMEOUT_COUNT);
        end else if (reload) begin
            timerCount <= loadValue;
        end else begin
            timerCount <= timerCount - RATE_W'(1);
        end
    end

    // Update alone with load bit clear must not reload
    update_noload_a: assert property (@(posedge clk_sys) disable iff (srst)
        (ioUpdate && !loadOnUpdate && !timeout && timerCount != '0)
        |=> timerCount == $past(timerCount) - RATE_W'(1))
        else $error("ramp timer reloaded on update with load bit clear");

    // Update with load bit set reloads next cycle
    update_load_a: assert property (@(posedge clk_sys) disable iff (srst)
        (ioUpdate && loadOnUpdate) |=> timerCount == $past(loadValue))
        else $error("ramp timer not reloaded on update");
endmodule : amp_ramp_timer

/* core/dds_mode_control_upper.sv */
// Upper main function control decode behind an AXI4-Lite slave
//
// Local design decisions: the address map and the AXI4-Lite slave port.
module dds_mode_control_upper
    import dds_ctrl_pkg::*;
#(
    parameter int PROFILES = 4
) (
    input wire logic clk_sys,
    input wire logic srst,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins from outside the clock domain
    input wire logic ioUpdatePin,
    input wire logic [1:0] profilePins,
    // RAM sequencer reports end of a segment, one-cycle pulse
    input wire logic segmentDone,
    // Settings towards the synthesis core
    output logic ramEnable,
    output dds_ctrl_pkg::ram_route_t ramRoute,
    output logic [1:0] activeProfile,
    output logic profileLooping,
    output logic keyingEnable,
    output logic keyingAuto,
    output logic [13:0] scaleOut,
    output logic [1:0] autoRampStep,
    output logic autoSyncEnable,
    output logic rampTick
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] ctrlStage_r;      // Written by software, not yet in force
    logic [31:0] ctrlActive_r;     // Copy the core actually follows
    logic [15:0] scaleStage_r;     // Amplitude scale factor, staged
    logic [15:0] scaleActive_r;    // Amplitude scale factor, in force
    logic [7:0] rampRate_r;        // Ramp rate reload value
    logic [1:0] loopProfile_r;     // Profile counter for the internal loop
    logic [2:0] pinSync;           // Update pin and profile pins, synchronised
    logic updDly_r;                // Previous synchronised update level
    logic ioUpdate;                // Rising edge of the update pin
    logic [7:0] timerCount;        // Ramp timer state, for status
    // Write channel state
    logic awHeld_r;
    logic wHeld_r;
    logic [7:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic doWrite;
    logic wrHit;
    // Read channel state
    logic [7:0] rdAddr;
    logic rdHit;
    logic [31:0] rdWord;
    // Decoded modes
    logic ramOn;
    logic keyOn;
    logic [2:0] loopField;
    logic loopOn;
    logic [1:0] loopLast;
    ram_route_t routeNxt;

    initial begin
        if (PROFILES != 4) begin
            $error("dds_mode_control_upper supports exactly four profiles");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Functions
    ////////////////////////////////////////////////////////////////////////////
    // Merge a write into a word under byte enables
    function automatic logic [31:0] strobeMerge(input logic [31:0] oldWord,
                                                input logic [31:0] newWord,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = oldWord;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = newWord[8*i +: 8];
            end
        end
        return res;
    endfunction : strobeMerge

    // True for any offset that holds a register
    function automatic logic isMapped(input logic [7:0] addr);
        return addr == OFF_CTRL || addr == OFF_ACTIVE || addr == OFF_SCALE ||
               addr == OFF_RAMP || addr == OFF_STATUS;
    endfunction : isMapped

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and update edge
    ////////////////////////////////////////////////////////////////////////////
    sync_two_flop #(
        .WIDTH(3)
    ) u_pinSync (
        .clk_sys(clk_sys),
        .srst(srst),
        .asyncIn({ioUpdatePin, profilePins}),
        .syncOut(pinSync)
    );

    // Delay the settled update level for edge detection
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            updDly_r <= 1'b0;
        end else begin
            updDly_r <= pinSync[2];
        end
    end

    assign ioUpdate = pinSync[2] && !updDly_r;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path
    ////////////////////////////////////////////////////////////////////////////
    // Address and data are taken in either order, one write at a time
    assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
    assign doWrite = awHeld_r && wHeld_r;
    assign wrHit = isMapped(awAddr_r);

    // Capture address, data, and raise the response
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (doWrite) begin
                // Both halves present: answer and free the channels
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register storage
    ////////////////////////////////////////////////////////////////////////////
    // Staged registers take software writes; read-only ones ignore them
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrlStage_r <= CTRL_RST;
            scaleStage_r <= SCALE_RST;
            rampRate_r <= RAMP_RST;
        end else if (doWrite) begin
            if (awAddr_r == OFF_CTRL) begin
                ctrlStage_r <= strobeMerge(ctrlStage_r, wData_r, wStrb_r);
            end
            if (awAddr_r == OFF_SCALE) begin
                scaleStage_r <= 16'(strobeMerge({16'h0000, scaleStage_r}, wData_r, wStrb_r));
            end
            if (awAddr_r == OFF_RAMP) begin
                rampRate_r <= 8'(strobeMerge({24'h000000, rampRate_r}, wData_r, wStrb_r));
            end
        end
    end

    // transfer on update
    // Staged words reach the core only at the update edge, so a multi-word
    // change takes effect at one instant instead of piecemeal.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrlActive_r <= CTRL_RST;
            scaleActive_r <= SCALE_RST;
        end else if (ioUpdate) begin
            ctrlActive_r <= ctrlStage_r;
            scaleActive_r <= scaleStage_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path
    ////////////////////////////////////////////////////////////////////////////
    assign s_axi_arready = !s_axi_rvalid;
    assign rdAddr = {s_axi_araddr[7:2], 2'b00};
    assign rdHit = isMapped(rdAddr);
    // Read word selection; status shows live block state
    assign rdWord = (rdAddr == OFF_CTRL) ? ctrlStage_r :
                    (rdAddr == OFF_ACTIVE) ? ctrlActive_r :
                    (rdAddr == OFF_SCALE) ? {16'h0000, scaleStage_r} :
                    (rdAddr == OFF_RAMP) ? {24'h000000, rampRate_r} :
                    (rdAddr == OFF_STATUS) ? {14'h0000, loopProfile_r, pinSync[1:0],
                                              timerCount, 6'h00} :
                    32'h0000_0000;

    // One-cycle read answer, held until taken
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdWord;
            s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode
    ////////////////////////////////////////////////////////////////////////////
    assign ramOn = ctrlActive_r[BIT_RAM_EN];
    assign keyOn = ctrlActive_r[BIT_KEY_EN];
    assign loopField = ctrlActive_r[LOOP_HI:LOOP_LO];
    // loop only with RAM in use
    assign loopOn = ramOn && (loopField != 3'b000);
    // Field values above three loop over all four profiles
    assign loopLast = (loopField > 3'd3) ? 2'd3 : loopField[1:0];
    assign routeNxt = !ramOn ? SRC_TONE :
                      ctrlActive_r[BIT_RAM_DEST] ? SRC_RAM_PHASE : SRC_RAM_FREQ;

    // automatic profile loop
    // Steps on each segment end; pins are ignored while looping.
    always_ff @(posedge clk_sys) begin
        if (srst || !loopOn) begin
            loopProfile_r <= 2'd0;
        end else if (segmentDone) begin
            loopProfile_r <= (loopProfile_r >= loopLast) ? 2'd0 : loopProfile_r + 2'd1;
        end
    end

    // Registered settings towards the core
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ramEnable <= 1'b0;
            ramRoute <= SRC_TONE;
            activeProfile <= 2'd0;
            profileLooping <= 1'b0;
            keyingEnable <= 1'b0;
            keyingAuto <= 1'b0;
            scaleOut <= FULL_SCALE;
            autoRampStep <= 2'd0;
            autoSyncEnable <= 1'b0;
        end else begin
            ramEnable <= ramOn;
            ramRoute <= routeNxt;
            activeProfile <= loopOn ? loopProfile_r : pinSync[1:0];
            profileLooping <= loopOn;
            keyingEnable <= keyOn;
            keyingAuto <= keyOn && ctrlActive_r[BIT_KEY_AUTO];
            scaleOut <= keyOn ? scaleActive_r[13:0] : FULL_SCALE;
            autoRampStep <= (keyOn && ctrlActive_r[BIT_KEY_AUTO]) ? scaleActive_r[15:14] : 2'd0;
            autoSyncEnable <= ctrlActive_r[BIT_AUTO_SYNC];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Amplitude ramp timer
    ////////////////////////////////////////////////////////////////////////////
    // load control selects update reload
    amp_ramp_timer #(
        .RATE_W(8)
    ) u_rampTimer (
        .clk_sys(clk_sys),
        .srst(srst),
        .rateWord(rampRate_r),
        .ioUpdate(ioUpdate),
        .loadOnUpdate(ctrlActive_r[BIT_RAMP_LOAD]),
        .rampTick(rampTick),
        .timerCount(timerCount)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    ////////////////////////////////////////////////////////////////////////////
    ram_off_tone_a: assert property (@(posedge clk_sys) disable iff (srst)
        !ramOn |=> (ramRoute == SRC_TONE) && !ramEnable)
        else $error("RAM route active with RAM disabled");

    ram_on_run_a: assert property (@(posedge clk_sys) disable iff (srst)
        ramOn |=> ramEnable)
        else $error("RAM not running with RAM bit set");

    dest_ignored_a: assert property (@(posedge clk_sys) disable iff (srst)
        ($changed(ctrlActive_r[BIT_RAM_DEST]) && !ramOn) |=> ramRoute == SRC_TONE)
        else $error("destination bit acted with RAM off");

    ram_freq_a: assert property (@(posedge clk_sys) disable iff (srst)
        (ramOn && !ctrlActive_r[BIT_RAM_DEST]) |=> ramRoute == SRC_RAM_FREQ)
        else $error("RAM not routed to tuning word");

    ram_phase_a: assert property (@(posedge clk_sys) disable iff (srst)
        (ramOn && ctrlActive_r[BIT_RAM_DEST]) |=> ramRoute == SRC_RAM_PHASE)
        else $error("RAM not routed to phase offset");

    loop_ignores_pins_a: assert property (@(posedge clk_sys) disable iff (srst)
        loopOn |=> profileLooping && activeProfile == $past(loopProfile_r))
        else $error("profile pins used during internal loop");

    keying_bypass_a: assert property (@(posedge clk_sys) disable iff (srst)
        !keyOn |=> !keyingEnable && !keyingAuto)
        else $error("keying applied while disabled");

    auto_key_a: assert property (@(posedge clk_sys) disable iff (srst)
        (keyOn && ctrlActive_r[BIT_KEY_AUTO]) |=> keyingAuto)
        else $error("automatic keying not selected");

    sync_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
        autoSyncEnable |-> $past(ctrlActive_r[BIT_AUTO_SYNC]))
        else $error("auto sync active with bit clear");

    scale_dead_a: assert property (@(posedge clk_sys) disable iff (srst)
        !keyOn |=> scaleOut == FULL_SCALE)
        else $error("scale factor acted with keying off");

    apply_on_update_a: assert property (@(posedge clk_sys) disable iff (srst)
        !ioUpdate |=> ctrlActive_r == $past(ctrlActive_r))
        else $error("control changed without update");
endmodule : dds_mode_control_upper

/* testbench/test_dds_mode_control_upper.sv */
module test_dds_mode_control_upper;
    timeunit 1ns;
    timeprecision 1ps;
    import dds_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Stimulus and observed signals
    logic clk_sys, srst;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic ioUpdatePin, segmentDone;
    logic [1:0] profilePins, activeProfile, autoRampStep;
    logic ramEnable, profileLooping, keyingEnable, keyingAuto, autoSyncEnable, rampTick;
    ram_route_t ramRoute;
    logic [13:0] scaleOut;
    logic [31:0] rd; // Last read data
    logic [1:0] rsp; // Last response
    int nErrors, checks, cycles, gap;

    dds_mode_control_upper #(.PROFILES(4)) u_dut (.clk_sys(clk_sys), .srst(srst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .ioUpdatePin(ioUpdatePin), .profilePins(profilePins), .segmentDone(segmentDone),
        .ramEnable(ramEnable), .ramRoute(ramRoute), .activeProfile(activeProfile),
        .profileLooping(profileLooping), .keyingEnable(keyingEnable),
        .keyingAuto(keyingAuto), .scaleOut(scaleOut), .autoRampStep(autoRampStep),
        .autoSyncEnable(autoSyncEnable), .rampTick(rampTick));

    ////////////////////////////////////////////////////////////////////////////
    // Clock at 4 ns
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Hang guard: the tests need well under two thousand cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            nErrors++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Comparison and verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            nErrors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        if (nErrors == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite master: readiness is judged just after an edge, so it holds at the next
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        logic awTake, wTake, bTake;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            #1;
            awTake = s_axi_awvalid && s_axi_awready;
            wTake = s_axi_wvalid && s_axi_wready;
            bTake = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge clk_sys);
            if (awTake) s_axi_awvalid <= 1'b0;
            if (wTake) s_axi_wvalid <= 1'b0;
            if (bTake) s_axi_bready <= 1'b0;
        end while (bTake !== 1'b1);
    endtask : axiWrite

    task automatic axiRead(input logic [7:0] a);
        logic arTake, rTake;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            #1;
            arTake = s_axi_arvalid && s_axi_arready;
            rTake = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge clk_sys);
            if (arTake) s_axi_arvalid <= 1'b0;
            if (rTake) s_axi_rready <= 1'b0;
        end while (rTake !== 1'b1);
    endtask : axiRead

    // Write control then pulse the update pin; outputs settle before return
    task automatic ctrlUpd(input logic [31:0] d);
        axiWrite(OFF_CTRL, d);
        @(posedge clk_sys);
        ioUpdatePin <= 1'b1;
        repeat (3) @(posedge clk_sys);
        ioUpdatePin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask : ctrlUpd

    // Cycles from one ramp tick to the next, optionally with an update in between
    task automatic tickGap(input logic doUpd, output int n);
        while (rampTick !== 1'b1) begin
            @(posedge clk_sys);
            #1;
        end
        n = 0;
        do begin
            @(posedge clk_sys);
            if (doUpd && n == 0) ioUpdatePin <= 1'b1;
            if (n == 3) ioUpdatePin <= 1'b0;
            #1;
            n++;
        end while (rampTick !== 1'b1 && n < 100);
    endtask : tickGap

    task automatic segStep();
        @(posedge clk_sys);
        segmentDone <= 1'b1;
        @(posedge clk_sys);
        segmentDone <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask : segStep

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        {ioUpdatePin, segmentDone} = '0;
        profilePins = 2'h3;
        {nErrors, checks, cycles} = '0;
        srst = 1'b1;
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        #1;
        check(ramEnable, 1'b0);
        check(ramRoute, SRC_TONE);
        check(scaleOut, FULL_SCALE);
        check(autoSyncEnable, 1'b0);
        axiRead(OFF_CTRL);
        check(rd, CTRL_RST);
        axiRead(OFF_SCALE);
        check(rd, SCALE_RST);
        // Unmapped place answers with an error; data and response checked apart
        axiRead(8'h14);
        check(rd, 32'h0000_0000);
        check(rsp, RESP_SLVERR);
        axiWrite(8'h14, 32'h0000_ffff);
        check(rsp, RESP_SLVERR);
        // Destination bit alone keeps the tone path
        ctrlUpd(32'h4000_0000);
        check(ramRoute, SRC_TONE);
        check(ramEnable, 1'b0);
        // New bits wait for the update
        axiWrite(OFF_CTRL, 32'h8000_0000);
        check(rsp, RESP_OKAY);
        axiRead(OFF_ACTIVE);
        check(rd, 32'h4000_0000);
        check(ramEnable, 1'b0);
        ctrlUpd(32'h8000_0000);
        check(ramEnable, 1'b1);
        check(ramRoute, SRC_RAM_FREQ);
        ctrlUpd(32'hc000_0000);
        check(ramRoute, SRC_RAM_PHASE);
        // Loop over profiles 0..2 ignores the pins
        ctrlUpd(32'h9000_0000);
        check({profileLooping, activeProfile}, 3'h4);
        for (int i = 1; i < 5; i++) begin
            segStep();
            check(activeProfile, i % 3);
        end
        // Loop field with the RAM off falls back to the pins
        ctrlUpd(32'h1000_0000);
        check({profileLooping, activeProfile}, 3'h3);
        // Loop field above three walks all four profiles from a cleared counter
        ctrlUpd(32'ha000_0000);
        check({profileLooping, activeProfile}, 3'h4);
        for (int i = 1; i < 6; i++) begin
            segStep();
            check(activeProfile, i % 4);
        end
        ctrlUpd(32'h0000_0000);
        check({profileLooping, activeProfile}, 3'h3);
        // Keying modes and scale factor
        axiWrite(OFF_SCALE, 32'h0000_8123);
        ctrlUpd(32'h0100_0000);
        check({keyingEnable, keyingAuto, autoRampStep}, 4'h0);
        check(scaleOut, FULL_SCALE);
        check(autoSyncEnable, 1'b0);
        ctrlUpd(32'h0200_0000);
        check({keyingEnable, keyingAuto, autoRampStep}, 4'h8);
        check(scaleOut, 14'h0123);
        ctrlUpd(32'h0380_0000);
        check({keyingEnable, keyingAuto, autoRampStep}, 4'he);
        check(autoSyncEnable, 1'b1);
        // Ramp timer reload with and without the update
        axiWrite(OFF_RAMP, 32'h0000_0008);
        axiRead(OFF_RAMP);
        check(rd, 32'h0000_0008);
        tickGap(1'b0, gap);
        tickGap(1'b0, gap);
        check(gap, 8);
        tickGap(1'b1, gap);
        check(gap, 8);
        ctrlUpd(32'h0400_0000);
        tickGap(1'b0, gap);
        check(gap, 8);
        tickGap(1'b1, gap);
        // Update acts three edges after the pin rises, then seven more to the tick
        check(gap, 11);
        final_report();
    end
endmodule : test_dds_mode_control_upper
